//--- rtl/rsp_dev_end.sv
// Processor end: reset, straps, start-up fault pin, interrupts, hold pins
// Summary of operation
// R1 - Bad access one cycle after last ready
// R2 - Bad-access strap picks who initializes system
// R3 - Reset clears logic, then start-up reruns
// R4 - In reset ignore inputs, outputs deasserted
// R5 - Reset held at least 41 cycles
// R6 - Reset released just after a clock edge
// R7 - Fault pin high during self-test, then low
// R8 - First eight words must sum to zero
// R9 - Line zero is message or interrupt
// R10 - Synchronous: one low, one high cycle
// R11 - Asynchronous: two low, two high cycles
// R12 - Line-zero strap sets processor number
// R13 - Line one is a direct interrupt
// R14 - Line two is interrupt or controller request
// R15 - Line three is interrupt or acknowledge out
// R16 - Hold pins depend on primary or secondary
// R17 - Straps captured at reset release, then frozen
// R18 - Two flip-flops before sequence check
`timescale 1ns/1ns
`default_nettype none
module rsp_dev_end #(
  parameter int CHECK_WORDS = rsp_pkg::CHECKSUM_WORDS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Link pins
  rsp_link_if.dev link,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  // Start-up engine
  input wire logic selftest_done,
  input wire logic selftest_ok,
  input wire logic mem_word_valid,
  input wire logic [31:0] mem_word,
  output logic init_running,
  output logic init_ok,
  // Bus engine
  input wire logic irq_acknowledge_out_begin,
  input wire logic irq_acknowledge_out_end,
  input wire logic bus_want,
  input wire logic bus_busy,
  output logic bus_owned,
  // Events and straps
  output logic [6:0] event_pulse,
  output logic proc_number,
  output logic init_owner_strap
);
  if (CHECK_WORDS < 1 || CHECK_WORDS > 256) begin : g_chk
    $error("CHECK_WORDS must lie in 1..256");
  end

  logic [3:0] meta_reg;
  logic [3:0] sync_reg;
  logic ready_d_reg;
  logic [3:0] ctrl_reg;
  logic [6:0] events_reg;
  rsp_pkg::rsp_state_t state_reg;
  rsp_pkg::rsp_state_t state_next;
  logic [31:0] sum_reg;
  logic [7:0] word_cnt_reg;
  logic fault_reg;
  logic ack_reg;
  logic hold_out_reg;
  logic owned_reg;
  wire [3:0] irq_level;
  wire [3:0] irq_fire;

  // Plain synchronisers for the non-interrupt pins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      // Reset bit starts asserted so start-up waits for the pin itself
      meta_reg <= 4'h1; // [R4]
      sync_reg <= 4'h1; // [R4]
    end else begin
      meta_reg <= {link.hold_pin_in, link.ready_last, link.bad_access_in,
                   link.sys_reset};
      sync_reg <= meta_reg;
    end
  end
  wire sys_rst_s = sync_reg[0];
  wire bad_s = sync_reg[1];
  wire ready_s = sync_reg[2];
  wire hold_in_s = sync_reg[3];
  wire dev_rst = !rst_n || sys_rst_s; // [R3] [R5]

  // Open-drain line three reads low as asserted
  wire [3:0] irq_pins = {!link.irq_line_three, link.irq_line_two,
                         link.irq_line_one, link.agent_message_request};
  for (genvar i = 0; i < 4; i++) begin : g_irq
    rsp_line_qual u_qual (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clr(sys_rst_s),
      .async_mode(ctrl_reg[rsp_pkg::CTRL_ASYNC_BIT]),
      .pin_in(irq_pins[i]),
      .level_out(irq_level[i]),
      .event_out(irq_fire[i])
    ); // [R18]
  end

  // Straps follow the pins in reset and freeze on the release edge
  always_ff @(posedge clk_sys) begin
    if (dev_rst) begin
      init_owner_strap <= bad_s; // [R2] [R17]
      proc_number <= !irq_level[0]; // [R12] [R17]
    end
  end
  wire primary = !proc_number;

  // Register decode
  wire wr_ctrl = reg_we && (reg_addr == rsp_pkg::RSP_CTRL_OFS);
  wire wr_events = reg_we && (reg_addr == rsp_pkg::RSP_EVENTS_OFS);
  wire [6:0] ev_clr = wr_events ? reg_wdata[6:0] : 7'h00;
  wire msg_mode = ctrl_reg[rsp_pkg::CTRL_MSG_BIT];
  wire extc_mode = ctrl_reg[rsp_pkg::CTRL_EXTC_BIT];
  wire ack_mode = ctrl_reg[rsp_pkg::CTRL_ACK_BIT];
  wire [31:0] status_word = {25'h0, owned_reg, state_reg, fault_reg,
                             init_owner_strap, proc_number};
  wire [31:0] rd_mux =
    (reg_addr == rsp_pkg::RSP_CTRL_OFS) ? {28'h0, ctrl_reg} :
    (reg_addr == rsp_pkg::RSP_STATUS_OFS) ? status_word :
    (reg_addr == rsp_pkg::RSP_EVENTS_OFS) ? {25'h0, events_reg} : 32'h0;

  // Event sources
  logic [6:0] ev_set;
  always_comb begin
    ev_set = 7'h00;
    ev_set[rsp_pkg::EV_IRQ0_BIT] = irq_fire[0] & !msg_mode; // [R9]
    ev_set[rsp_pkg::EV_MSG_BIT] = irq_fire[0] & msg_mode; // [R9]
    ev_set[rsp_pkg::EV_IRQ1_BIT] = irq_fire[1]; // [R13]
    ev_set[rsp_pkg::EV_IRQ2_BIT] = irq_fire[2] & !extc_mode; // [R14]
    ev_set[rsp_pkg::EV_EXTREQ_BIT] = irq_fire[2] & extc_mode; // [R14]
    ev_set[rsp_pkg::EV_IRQ3_BIT] = irq_fire[3] & !ack_mode; // [R15]
    // Both pins cross the same depth of flops, so the spacing survives
    ev_set[rsp_pkg::EV_BAD_BIT] = ready_d_reg & bad_s; // [R1]
    if (dev_rst) begin
      ev_set = 7'h00; // [R4]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (dev_rst) begin
      ctrl_reg <= rsp_pkg::CTRL_RESET; // [R3]
      events_reg <= rsp_pkg::EV_RESET;
      event_pulse <= 7'h00;
      ready_d_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= reg_wdata[3:0];
      end
      // A new event beats a clear in the same cycle
      events_reg <= (events_reg & ~ev_clr) | ev_set;
      event_pulse <= ev_set;
      ready_d_reg <= ready_s; // [R1]
    end
  end

  // Reads answer in the next cycle even during system reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= reg_re ? rd_mux : 32'h0;
    end
  end

  // Start-up sequence
  wire [31:0] sum_new = sum_reg + mem_word;
  wire last_word = (word_cnt_reg == 8'(CHECK_WORDS - 1));
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      rsp_pkg::RSP_ST_RESET: state_next = rsp_pkg::RSP_ST_SELFTEST; // [R7]
      rsp_pkg::RSP_ST_SELFTEST: begin
        if (selftest_done) begin
          state_next = selftest_ok ? rsp_pkg::RSP_ST_CHECKSUM
                                   : rsp_pkg::RSP_ST_FAILED;
        end
      end
      rsp_pkg::RSP_ST_CHECKSUM: begin
        if (mem_word_valid && last_word) begin
          state_next = (sum_new == 32'h0) ? rsp_pkg::RSP_ST_RUN
                                          : rsp_pkg::RSP_ST_FAILED; // [R8]
        end
      end
      rsp_pkg::RSP_ST_RUN: state_next = rsp_pkg::RSP_ST_RUN;
      rsp_pkg::RSP_ST_FAILED: state_next = rsp_pkg::RSP_ST_FAILED; // [R8]
      default: state_next = rsp_pkg::RSP_ST_RESET;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (dev_rst) begin
      state_reg <= rsp_pkg::RSP_ST_RESET; // [R3]
      fault_reg <= 1'b0; // [R4]
      sum_reg <= 32'h0;
      word_cnt_reg <= 8'h0;
    end else begin
      state_reg <= state_next;
      fault_reg <= (state_next == rsp_pkg::RSP_ST_SELFTEST) ||
                   (state_next == rsp_pkg::RSP_ST_FAILED); // [R7] [R8]
      if (state_reg == rsp_pkg::RSP_ST_CHECKSUM && mem_word_valid) begin
        sum_reg <= sum_new; // [R8]
        word_cnt_reg <= word_cnt_reg + 8'h1;
      end
    end
  end

  // Acknowledge frame, hold pins
  wire run = (state_reg == rsp_pkg::RSP_ST_RUN);
  wire hold_next = primary ? (hold_in_s & !bus_busy) : bus_want; // [R16]
  always_ff @(posedge clk_sys) begin
    if (dev_rst || !ack_mode) begin
      ack_reg <= 1'b0; // [R4]
    end else if (irq_acknowledge_out_begin) begin
      ack_reg <= 1'b1; // [R15]
    end else if (irq_acknowledge_out_end) begin
      ack_reg <= 1'b0; // [R15]
    end
  end
  always_ff @(posedge clk_sys) begin
    if (dev_rst || !run) begin
      hold_out_reg <= 1'b0; // [R4]
      owned_reg <= 1'b0;
    end else begin
      hold_out_reg <= hold_next; // [R16]
      owned_reg <= primary ? !hold_next : (bus_want & hold_in_s); // [R16]
    end
  end

  assign link.init_fault_out = fault_reg;
  assign link.hold_pin_out = hold_out_reg;
  assign link.irq_acknowledge_out = 1'b0;
  assign link.irq_acknowledge_oe = ack_reg; // [R15]
  assign init_running = (state_reg == rsp_pkg::RSP_ST_SELFTEST) ||
                        (state_reg == rsp_pkg::RSP_ST_CHECKSUM);
  assign init_ok = run;
  assign bus_owned = owned_reg;
endmodule : rsp_dev_end
`default_nettype wire

//--- rtl/rsp_host_end.sv
// System end: reset source, bad-access reporter, interrupt line shaper
`timescale 1ns/1ns
`default_nettype none
module rsp_host_end #(
  parameter int RESET_CYCLES = rsp_pkg::RESET_HOLD_CYCLES,
  parameter int PULSE_CYCLES = rsp_pkg::QUAL_ASYNC_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Link pins
  rsp_link_if.host link,
  // Reset and straps
  input wire logic reset_req,
  input wire logic strap_init_owner,
  input wire logic strap_primary,
  output logic in_reset,
  // Transfer end
  input wire logic xfer_end,
  input wire logic xfer_err,
  // Interrupt requests
  input wire logic [3:0] irq_req,
  output logic [3:0] irq_busy,
  // Hold and observation
  input wire logic hold_drive,
  output logic fault_seen,
  output logic hold_seen,
  output logic irq3_low_seen
);
  if (RESET_CYCLES < rsp_pkg::RESET_HOLD_CYCLES || RESET_CYCLES > 255)
  begin : g_chk_rst
    $error("RESET_CYCLES must lie in 41..255");
  end
  if (PULSE_CYCLES < rsp_pkg::QUAL_ASYNC_CYCLES || PULSE_CYCLES > 7)
  begin : g_chk_pulse
    $error("PULSE_CYCLES must lie in 2..7");
  end

  logic [7:0] rst_cnt_reg;
  logic ready_reg;
  logic err_reg;
  logic bad_reg;
  logic hold_reg;
  logic [3:0] lvl_reg;
  logic [3:0] irq_cnt_reg [4];
  logic [2:0] meta_reg;
  logic [2:0] sync_reg;

  // Reset changes only right after a clock edge
  wire [7:0] rst_cnt_next = reset_req ? 8'(RESET_CYCLES) :
                            (rst_cnt_reg != 8'h0) ? rst_cnt_reg - 8'h1 : 8'h0;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rst_cnt_reg <= 8'(RESET_CYCLES); // [R5]
      in_reset <= 1'b1;
    end else begin
      rst_cnt_reg <= rst_cnt_next;
      in_reset <= (rst_cnt_next != 8'h0); // [R5] [R6]
    end
  end

  // Ready of the last data cycle, then the error flag one cycle later
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ready_reg <= 1'b0;
      err_reg <= 1'b0;
      bad_reg <= 1'b0;
    end else begin
      ready_reg <= xfer_end & !in_reset;
      err_reg <= xfer_err & xfer_end & !in_reset;
      bad_reg <= in_reset ? strap_init_owner
                          : (ready_reg & err_reg); // [R1] [R2]
    end
  end

  // Each request makes a low phase then a high phase, each PULSE_CYCLES long
  for (genvar i = 0; i < 4; i++) begin : g_line
    always_ff @(posedge clk_sys) begin
      if (!rst_n || in_reset) begin
        irq_cnt_reg[i] <= 4'h0;
        lvl_reg[i] <= 1'b0;
      end else if (irq_cnt_reg[i] == 4'h0) begin
        irq_cnt_reg[i] <= irq_req[i] ? 4'(2 * PULSE_CYCLES) : 4'h0;
        lvl_reg[i] <= 1'b0;
      end else begin
        irq_cnt_reg[i] <= irq_cnt_reg[i] - 4'h1;
        lvl_reg[i] <= (irq_cnt_reg[i] <= 4'(PULSE_CYCLES + 1)) &&
                      (irq_cnt_reg[i] != 4'h1); // [R10] [R11]
      end
    end
    assign irq_busy[i] = (irq_cnt_reg[i] != 4'h0);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hold_reg <= 1'b0;
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
    end else begin
      hold_reg <= hold_drive & !in_reset;
      meta_reg <= {!link.irq_line_three, link.hold_pin_out,
                   link.init_fault_out};
      sync_reg <= meta_reg;
    end
  end

  assign link.sys_reset = in_reset;
  assign link.bad_access_in = bad_reg;
  assign link.ready_last = ready_reg;
  assign link.agent_message_request = in_reset ? strap_primary
                                               : lvl_reg[0]; // [R12]
  assign link.irq_line_one = lvl_reg[1];
  assign link.irq_line_two = lvl_reg[2];
  assign link.host_irq3_out = 1'b0;
  assign link.host_irq3_oe = lvl_reg[3];
  assign link.hold_pin_in = hold_reg;
  assign fault_seen = sync_reg[0];
  assign hold_seen = sync_reg[1];
  assign irq3_low_seen = sync_reg[2];
endmodule : rsp_host_end
`default_nettype wire

//--- rtl/rsp_line_qual.sv
// Two-stage synchroniser and deasserted-then-asserted qualifier for one line
`timescale 1ns/1ns
`default_nettype none
module rsp_line_qual (
  // Clock and resets
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clr,
  // Mode
  input wire logic async_mode,
  // Line
  input wire logic pin_in,
  output logic level_out,
  output logic event_out
);
  logic meta_reg;
  logic sync_reg;
  logic [1:0] lo_cnt_reg;
  logic [1:0] hi_cnt_reg;
  logic arm_reg;
  wire [1:0] need = async_mode ? 2'(rsp_pkg::QUAL_ASYNC_CYCLES)
                               : 2'(rsp_pkg::QUAL_SYNC_CYCLES);
  wire [1:0] lo_next = (lo_cnt_reg == 2'h3) ? lo_cnt_reg : lo_cnt_reg + 2'h1;
  wire [1:0] hi_next = hi_cnt_reg + 2'h1;
  wire fire = sync_reg & arm_reg & (hi_next >= need);

  // Strap sampling needs the level during system reset, so only rst_n clears
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg; // [R18]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || clr) begin
      lo_cnt_reg <= 2'h0;
      hi_cnt_reg <= 2'h0;
      arm_reg <= 1'b0;
      event_out <= 1'b0;
    end else if (!sync_reg) begin
      lo_cnt_reg <= lo_next;
      hi_cnt_reg <= 2'h0;
      arm_reg <= (lo_next >= need); // [R10] [R11]
      event_out <= 1'b0;
    end else begin
      lo_cnt_reg <= 2'h0;
      hi_cnt_reg <= (arm_reg && !fire) ? hi_next : 2'h0;
      arm_reg <= arm_reg & !fire;
      event_out <= fire; // [R10] [R11]
    end
  end

  assign level_out = sync_reg;
endmodule : rsp_line_qual
`default_nettype wire

//--- rtl/rsp_link_if.sv
// Board-level pins between the processor end and the system end
`timescale 1ns/1ns
`default_nettype none
interface rsp_link_if;
  // Driven by the system end
  logic sys_reset;
  logic bad_access_in;
  logic ready_last;
  logic agent_message_request;
  logic irq_line_one;
  logic irq_line_two;
  logic hold_pin_in;
  logic host_irq3_out;
  logic host_irq3_oe;
  // Driven by the processor end
  logic init_fault_out;
  logic hold_pin_out;
  logic irq_acknowledge_out;
  logic irq_acknowledge_oe;
  // Open-drain wire with pull-up, low means asserted
  wire irq_line_three;
  assign irq_line_three = !((irq_acknowledge_oe & !irq_acknowledge_out) |
                            (host_irq3_oe & !host_irq3_out));
  modport dev (
    input sys_reset, bad_access_in, ready_last, agent_message_request,
    input irq_line_one, irq_line_two, hold_pin_in, irq_line_three,
    output init_fault_out, hold_pin_out,
    output irq_acknowledge_out, irq_acknowledge_oe
  );
  modport host (
    output sys_reset, bad_access_in, ready_last, agent_message_request,
    output irq_line_one, irq_line_two, hold_pin_in,
    output host_irq3_out, host_irq3_oe,
    input init_fault_out, hold_pin_out, irq_line_three
  );
endinterface : rsp_link_if
`default_nettype wire

//--- rtl/rsp_pkg.sv
// Shared constants and types for the reset, start-up and interrupt pin logic
package rsp_pkg;
  // Controller register offsets
  localparam logic [7:0] RSP_CTRL_OFS = 8'h00;
  localparam logic [7:0] RSP_STATUS_OFS = 8'h04;
  localparam logic [7:0] RSP_EVENTS_OFS = 8'h08;
  // Control register fields
  localparam int CTRL_W = 4;
  localparam int CTRL_MSG_BIT = 0;
  localparam int CTRL_EXTC_BIT = 1;
  localparam int CTRL_ACK_BIT = 2;
  localparam int CTRL_ASYNC_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // Event register fields
  localparam int EV_W = 7;
  localparam int EV_IRQ0_BIT = 0;
  localparam int EV_IRQ1_BIT = 1;
  localparam int EV_IRQ2_BIT = 2;
  localparam int EV_IRQ3_BIT = 3;
  localparam int EV_MSG_BIT = 4;
  localparam int EV_EXTREQ_BIT = 5;
  localparam int EV_BAD_BIT = 6;
  localparam logic [6:0] EV_RESET = 7'h00;
  // Status register fields
  localparam int ST_PROC_BIT = 0;
  localparam int ST_OWNER_BIT = 1;
  localparam int ST_FAULT_BIT = 2;
  localparam int ST_STATE_LSB = 3;
  localparam int ST_OWNED_BIT = 6;
  // Cycle counts
  localparam int RESET_HOLD_CYCLES = 41;
  localparam int CHECKSUM_WORDS = 8;
  localparam int QUAL_SYNC_CYCLES = 1;
  localparam int QUAL_ASYNC_CYCLES = 2;
  // Start-up sequence
  typedef enum logic [2:0] {
    RSP_ST_RESET = 3'h0,
    RSP_ST_SELFTEST = 3'h1,
    RSP_ST_CHECKSUM = 3'h3,
    RSP_ST_RUN = 3'h2,
    RSP_ST_FAILED = 3'h6
  } rsp_state_t;
endpackage : rsp_pkg

//--- sim/rsp_link_chk.sv
// Link pin assertions for the reset, start-up and interrupt pin logic
`timescale 1ns/1ns
`default_nettype none
module rsp_link_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Link pins
  input wire logic sys_reset,
  input wire logic bad_access_in,
  input wire logic ready_last,
  input wire logic irq_line_one,
  input wire logic host_irq3_out,
  input wire logic host_irq3_oe,
  input wire logic init_fault_out,
  input wire logic hold_pin_out,
  input wire logic irq_acknowledge_out,
  input wire logic irq_acknowledge_oe,
  input wire logic irq_line_three
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Saturates so a long reset never wraps back under the minimum
  logic [6:0] rst_cnt;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !sys_reset) rst_cnt <= 7'h00;
    else if (rst_cnt != 7'h7f) rst_cnt <= rst_cnt + 7'h01;
  end
  a_reset_length: assert property (
    $fell(sys_reset) |-> rst_cnt >= 7'h29)
    else $error("Reset released too early");
  a_reset_quiet: assert property (
    sys_reset [*5] |-> !init_fault_out && !hold_pin_out && !irq_acknowledge_oe)
    else $error("Output active during reset");
  a_fault_start: assert property (
    $fell(sys_reset) |-> ##[1:6] init_fault_out)
    else $error("No fault flag during self-test");
  a_bad_timing: assert property (
    bad_access_in && !sys_reset && !$past(sys_reset) && !$past(sys_reset, 2)
    |-> $past(ready_last))
    else $error("Bad access not right after last ready");
  a_ready_single: assert property (
    ready_last |=> !ready_last)
    else $error("Last ready longer than one cycle");
  a_ack_drain: assert property (
    irq_acknowledge_oe |-> !irq_acknowledge_out && !irq_line_three)
    else $error("Acknowledge not pulling low");
  a_host_drain: assert property (
    host_irq3_oe |-> !host_irq3_out && !irq_line_three)
    else $error("Line three not pulled low");
  a_irq_shape: assert property (
    $rose(irq_line_one) && $past(rst_n, 4)
    |-> !$past(irq_line_one, 2) ##1 irq_line_one)
    else $error("Interrupt line shape too short");
  c_reset_end: cover property ($fell(sys_reset));
  c_ack: cover property (irq_acknowledge_oe);
  c_bad: cover property (ready_last ##1 bad_access_in);
endmodule : rsp_link_chk
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench joining the processor end and the system end
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_sys, rst_n, reg_we, reg_re, selftest_done, selftest_ok;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, mem_word;
  logic mem_word_valid, init_running, init_ok, irq_acknowledge_out_begin, irq_acknowledge_out_end;
  logic bus_want, bus_busy, bus_owned, proc_number, init_owner_strap;
  logic [6:0] event_pulse;
  logic reset_req, strap_init_owner, strap_primary, in_reset, xfer_end;
  logic xfer_err, hold_drive, fault_seen, hold_seen, irq3_low_seen;
  logic [3:0] irq_req, irq_busy;
  int bad_count, cmp_count;
  rsp_link_if lk ();
  rsp_dev_end u_rsp_dev_end (.clk_sys(clk_sys), .rst_n(rst_n), .link(lk.dev),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .selftest_done(selftest_done),
    .selftest_ok(selftest_ok), .mem_word_valid(mem_word_valid),
    .mem_word(mem_word), .init_running(init_running), .init_ok(init_ok),
    .irq_acknowledge_out_begin(irq_acknowledge_out_begin), .irq_acknowledge_out_end(irq_acknowledge_out_end), .bus_want(bus_want),
    .bus_busy(bus_busy), .bus_owned(bus_owned), .event_pulse(event_pulse),
    .proc_number(proc_number), .init_owner_strap(init_owner_strap));
  rsp_host_end u_rsp_host_end (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(lk.host), .reset_req(reset_req), .strap_init_owner(strap_init_owner),
    .strap_primary(strap_primary), .in_reset(in_reset), .xfer_end(xfer_end),
    .xfer_err(xfer_err), .irq_req(irq_req), .irq_busy(irq_busy),
    .hold_drive(hold_drive), .fault_seen(fault_seen), .hold_seen(hold_seen),
    .irq3_low_seen(irq3_low_seen));
  rsp_link_chk u_rsp_link_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .sys_reset(lk.sys_reset), .bad_access_in(lk.bad_access_in),
    .ready_last(lk.ready_last), .irq_line_one(lk.irq_line_one),
    .host_irq3_out(lk.host_irq3_out), .host_irq3_oe(lk.host_irq3_oe),
    .init_fault_out(lk.init_fault_out), .hold_pin_out(lk.hold_pin_out),
    .irq_acknowledge_out(lk.irq_acknowledge_out),
    .irq_acknowledge_oe(lk.irq_acknowledge_oe),
    .irq_line_three(lk.irq_line_three));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic check1(input logic seen, input logic exp);
    check({31'h0, seen}, {31'h0, exp});
  endtask : check1
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // Ends just after an edge so reads see settled values
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk_sys);
    reg_we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic grab(output logic [6:0] s);
    s = 7'h00;
    repeat (30) begin
      @(posedge clk_sys);
      #1 s = s | event_pulse;
    end
  endtask : grab
  function automatic int ev_idx(input int line, input logic [3:0] c);
    if (line == 0 && c[rsp_pkg::CTRL_MSG_BIT]) return rsp_pkg::EV_MSG_BIT;
    if (line == 2 && c[rsp_pkg::CTRL_EXTC_BIT]) return rsp_pkg::EV_EXTREQ_BIT;
    return line;
  endfunction : ev_idx
  function automatic logic [31:0] st_exp(input logic own, input logic pri);
    // A primary master owns the bus while nobody holds it
    return {25'h0, pri, rsp_pkg::RSP_ST_RUN, 1'b0, own, !pri};
  endfunction : st_exp
  task automatic sys_rst(input logic own, input logic pri);
    int n;
    strap_init_owner <= own;
    strap_primary <= pri;
    @(posedge clk_sys);
    reset_req <= 1'b1;
    @(posedge clk_sys);
    reset_req <= 1'b0;
    tick(4);
    check1(lk.init_fault_out, 1'b0);
    n = 0;
    while (in_reset !== 1'b0) begin
      tick(1);
      n++;
      if (n > 100) begin
        bad_count++;
        end_of_test();
      end
    end
    tick(4);
    check1(proc_number, !pri);
    check1(init_owner_strap, own);
  endtask : sys_rst
  task automatic boot(input logic good);
    logic [31:0] acc, w;
    acc = 32'h0;
    check1(lk.init_fault_out, 1'b1);
    check1(init_running, 1'b1);
    selftest_done <= 1'b1;
    selftest_ok <= 1'b1;
    tick(1);
    selftest_done <= 1'b0;
    tick(3);
    check1(lk.init_fault_out, 1'b0);
    for (int i = 0; i < 8; i++) begin
      w = (i == 7) ? (good ? -acc : ~acc) : $urandom;
      acc = acc + w;
      mem_word <= w;
      mem_word_valid <= 1'b1;
      tick(1);
    end
    mem_word_valid <= 1'b0;
    tick(24);
    check1(lk.init_fault_out, !good);
    check1(init_ok, good);
    check1(fault_seen, !good);
  endtask : boot
  task automatic hold_try(input logic pri);
    hold_drive <= 1'b1;
    bus_want <= !pri;
    tick(6);
    check1(lk.hold_pin_out, 1'b1);
    check1(hold_seen, 1'b1);
    check1(bus_owned, !pri);
    bus_busy <= pri;
    hold_drive <= pri;
    tick(6);
    check1(lk.hold_pin_out, !pri);
    check1(hold_seen, !pri);
    check1(bus_owned, pri);
    hold_drive <= 1'b0;
    bus_want <= 1'b0;
    bus_busy <= 1'b0;
  endtask : hold_try
  initial begin
    logic [31:0] d;
    logic [6:0] s, e;
    logic [3:0] c;
    int line, seed_v;
    logic own;
    {rst_n, reg_we, reg_re, selftest_done, selftest_ok, mem_word_valid} = '0;
    {irq_acknowledge_out_begin, irq_acknowledge_out_end, bus_want, bus_busy, reset_req, xfer_end} = '0;
    {xfer_err, hold_drive, strap_init_owner, strap_primary} = '0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    mem_word = 32'h0;
    irq_req = 4'h0;
    bad_count = 0;
    cmp_count = 0;
    seed_v = $urandom(7054);
    tick(16);
    rst_n <= 1'b1;
    sys_rst(1'b1, 1'b1);
    boot(1'b1);
    rd(rsp_pkg::RSP_STATUS_OFS, d);
    check(d, st_exp(1'b1, 1'b1));
    hold_try(1'b1);
    $display("Start-up and primary hold done");
    for (int k = 0; k < 24; k++) begin
      c = (k < 16) ? 4'(k * 7) : 4'($urandom);
      line = (k < 16) ? k / 4 : int'($urandom % 4);
      wr(rsp_pkg::RSP_CTRL_OFS, {28'h0, c});
      irq_req <= 4'h1 << line;
      @(posedge clk_sys);
      irq_req <= 4'h0;
      grab(s);
      e = (line == 3 && c[rsp_pkg::CTRL_ACK_BIT]) ? 7'h00
                                                  : 7'(1 << ev_idx(line, c));
      check({28'h0, irq_busy}, 32'h0);
      check({25'h0, s}, {25'h0, e});
      rd(rsp_pkg::RSP_EVENTS_OFS, d);
      check(d, {25'h0, e});
      wr(rsp_pkg::RSP_EVENTS_OFS, 32'h7f);
      rd(rsp_pkg::RSP_EVENTS_OFS, d);
      check(d, 32'h0);
    end
    $display("Interrupt lines done");
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      xfer_end <= 1'b1;
      xfer_err <= k[0];
      @(posedge clk_sys);
      xfer_end <= 1'b0;
      xfer_err <= 1'b0;
      grab(s);
      check({25'h0, s}, k[0] ? 32'h40 : 32'h0);
    end
    wr(rsp_pkg::RSP_CTRL_OFS, 32'h4);
    irq_acknowledge_out_begin <= 1'b1;
    tick(1);
    irq_acknowledge_out_begin <= 1'b0;
    tick(3);
    check1(lk.irq_acknowledge_oe, 1'b1);
    check1(lk.irq_line_three, 1'b0);
    check1(irq3_low_seen, 1'b1);
    irq_acknowledge_out_end <= 1'b1;
    tick(1);
    irq_acknowledge_out_end <= 1'b0;
    tick(3);
    check1(lk.irq_line_three, 1'b1);
    check1(irq3_low_seen, 1'b0);
    check1(proc_number, 1'b0);
    $display("Bad access and acknowledge done");
    own = 1'($urandom);
    sys_rst(own, 1'b0);
    rd(rsp_pkg::RSP_CTRL_OFS, d);
    check(d, 32'h0);
    boot(1'b1);
    rd(rsp_pkg::RSP_STATUS_OFS, d);
    check(d, st_exp(own, 1'b0));
    hold_try(1'b0);
    $display("Second reset and secondary hold done");
    sys_rst(1'b0, 1'b1);
    boot(1'b0);
    tick(40);
    check1(lk.init_fault_out, 1'b1);
    $display("Checksum init_fault_out done");
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
